// [discharge_core_model.sv]
/*
  Converter core stand-in: answers each discharge start with a done pulse.
  Assumes registered start and switch levels on clk.
*/
`timescale 1ns/1ps
module discharge_core_model
  import temp_ratio_pkg::*;
(
  input wire logic clk,
  input wire logic discharge_start,
  input wire temp_ratio_pkg::switch_ctrl_t sw,
  input wire logic [23:0] t_ref,
  input wire logic [23:0] t_ser,
  input wire logic [7:0] delay,
  output logic discharge_done,
  output logic [temp_ratio_pkg::CNT_W-1:0] discharge_time
);
  // ==========================================
  // Answer path
  initial
  begin
    discharge_done = 1'b0;
    discharge_time = 24'h5A5A5A;
    forever
    begin
      @(posedge clk);
      if (discharge_start)
      begin
        repeat (delay) @(posedge clk);
        #1;
        discharge_done = 1'b1;
        discharge_time = sw.temp_series_in ? t_ser : t_ref;
        @(posedge clk);
        #1;
        discharge_done = 1'b0;
        // Stale time inverted, never trusted
        discharge_time = ~discharge_time;
      end
    end
  end
endmodule

// [internal_temp_ratio_measure.sv]
/*
  Internal temperature ratio sequencer: reference discharge, then series discharge,
  then ratio posting at the end of each measurement cycle.
  Assumes the converter core pulses cycle_end and reports each discharge time
  with a done pulse; all inputs are on the clk domain.
*/
// Overview of operation
// - One shared select drives both temperature resistors identically.
// - Register 14 select bit chooses 300 or 600 ohm resistor.
// - First discharge uses both reference gauges in parallel, resistors excluded.
// - Second discharge uses each gauge in series with its resistor.
// - Control unit sets port switches for each discharge path.
// - Ratio of the two results, temp resistance over gauge, is reported.
// - Measurement runs only when configuration register 1 bit 8 set.
// - At most one measurement per cycle, started at the cycle's end.
// - Ratio posted to result location 245 once the division after the series discharge ends.
`timescale 1ns/1ps
module internal_temp_ratio_measure
  import temp_ratio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] cfg1,
  input wire logic [23:0] cfg14,
  input wire logic cycle_end,
  input wire logic discharge_done,
  input wire logic [temp_ratio_pkg::CNT_W-1:0] discharge_time,
  output temp_ratio_pkg::switch_ctrl_t sw,
  output logic discharge_start,
  output temp_ratio_pkg::result_wr_t result,
  output logic [temp_ratio_pkg::CNT_W-1:0] ratio_out
);
  import temp_ratio_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {IDLE, REF_RUN, SER_RUN, DIVIDE, POST} phase_t;

  typedef struct packed {
    phase_t phase;
    switch_ctrl_t sw;
    logic start;
    result_wr_t result;
    logic [CNT_W-1:0] ratio;
    logic [CNT_W-1:0] ref_t;
    logic [CNT_W-1:0] rem;
    logic [CNT_W-1:0] quo;
    logic [4:0] bit_cnt;
  } state_t;

  state_t s_q;
  state_t s_d;

  // One restoring division step: remainder doubled against the reference time
  function automatic logic [CNT_W:0] div_step(input logic [CNT_W-1:0] r,
                                              input logic [CNT_W-1:0] d);
    logic [CNT_W:0] t;
    t = {r, 1'b0};
    if (t >= {1'b0, d})
      div_step = t - {1'b0, d};
    else
      div_step = t;
  endfunction

  logic [CNT_W:0] step;

  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.result.wr = 1'b0;
    step = div_step(s_q.rem, s_q.ref_t);
    s_d.sw.temp_resistor_value_select = cfg14[CFG14_TEMP_SEL_BIT];
    // Busy phases ignore cycle_end, so at most one run per cycle
    case (s_q.phase)
      IDLE:
      begin
        s_d.sw.gauge_port_c_second = 1'b0;
        s_d.sw.gauge_port_d_first = 1'b0;
        s_d.sw.temp_series_in = 1'b0;
        if (cycle_end && cfg1[CFG1_TEMP_EN_BIT])
        begin
          s_d.sw.gauge_port_c_second = 1'b1;
          s_d.sw.gauge_port_d_first = 1'b1;
          s_d.start = 1'b1;
          s_d.phase = REF_RUN;
        end
      end
      REF_RUN:
        if (discharge_done)
        begin
          // switch setting
          // Floored at one so the divider never sees a zero divisor
          s_d.ref_t = (discharge_time == CNT_RESET) ? 24'h000001 : discharge_time;
          s_d.sw.temp_series_in = 1'b1;
          s_d.start = 1'b1;
          s_d.phase = SER_RUN;
        end
      SER_RUN:
        if (discharge_done)
        begin
          // Only the excess of series time over reference time is divided; zero when there is none
          s_d.rem = (discharge_time > s_q.ref_t) ? discharge_time - s_q.ref_t : CNT_RESET;
          s_d.quo = CNT_RESET;
          s_d.bit_cnt = 5'(FRAC_W);
          s_d.sw.gauge_port_c_second = 1'b0;
          s_d.sw.gauge_port_d_first = 1'b0;
          s_d.sw.temp_series_in = 1'b0;
          s_d.phase = DIVIDE;
        end
      DIVIDE:
      begin
        s_d.rem = step[CNT_W-1:0];
        s_d.quo = {s_q.quo[CNT_W-2:0], step != {s_q.rem, 1'b0}};
        s_d.bit_cnt = s_q.bit_cnt - 5'h01;
        if (s_q.bit_cnt == 5'h01)
          s_d.phase = POST;
      end
      POST:
      begin
        s_d.ratio = s_q.quo;
        s_d.result.wr = 1'b1;
        s_d.result.addr = RESULT_ADDR;
        s_d.result.data = s_q.quo;
        s_d.phase = IDLE;
      end
      default:
        s_d.phase = IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // All outputs read zero while reset is held
      s_q <= '0;
      s_q.phase <= IDLE;
    end
    else
      s_q <= s_d;
  end

  assign sw = s_q.sw;
  assign discharge_start = s_q.start;
  assign result = s_q.result;
  assign ratio_out = s_q.ratio;

  // ==========================================================
  // Checks
  ref_path_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == REF_RUN) |-> (sw.gauge_port_c_second && sw.gauge_port_d_first
      && !sw.temp_series_in))
    else $error("reference path wrong");
  ser_path_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == SER_RUN) |-> (sw.gauge_port_c_second && sw.gauge_port_d_first
      && sw.temp_series_in))
    else $error("series path missing");
  enable_gate_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == IDLE && cycle_end && !cfg1[CFG1_TEMP_EN_BIT]) |=> s_q.phase == IDLE)
    else $error("ran while disabled");
  sel_follow_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> sw.temp_resistor_value_select == $past(cfg14[CFG14_TEMP_SEL_BIT]))
    else $error("select not following");
  post_addr_a: assert property (@(posedge clk) disable iff (reset)
    result.wr |-> (result.addr == RESULT_ADDR && result.data == ratio_out))
    else $error("bad post");
  ratio_hold_a: assert property (@(posedge clk) disable iff (reset)
    !$past(result.wr) && !result.wr |-> $stable(ratio_out))
    else $error("ratio changed without post");
  start_pulse_a: assert property (@(posedge clk) disable iff (reset)
    discharge_start |=> !discharge_start)
    else $error("start not a pulse");
  divide_len_a: assert property (@(posedge clk) disable iff (reset)
    ($rose(s_q.phase == DIVIDE)) |-> ##20 (s_q.phase == POST))
    else $error("divide length wrong");

  // ==========================================================
  // Sequencing checks
  start_first_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == IDLE && cycle_end && cfg1[CFG1_TEMP_EN_BIT]) |=> (discharge_start
      && s_q.phase == REF_RUN))
    else $error("reference run not started");
  series_next_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == REF_RUN && discharge_done) |=> (discharge_start && s_q.phase == SER_RUN))
    else $error("series run not started");
  idle_ports_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == IDLE || s_q.phase == DIVIDE || s_q.phase == POST)
      |-> !(sw.gauge_port_c_second || sw.gauge_port_d_first || sw.temp_series_in))
    else $error("ports switched outside a run");
  busy_refuse_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == SER_RUN && cycle_end && !discharge_done) |=> s_q.phase == SER_RUN)
    else $error("busy run disturbed");
  done_ignored_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == IDLE && discharge_done && !cycle_end) |=> s_q.phase == IDLE)
    else $error("stray done accepted");
  start_phase_a: assert property (@(posedge clk) disable iff (reset)
    discharge_start |-> (s_q.phase == REF_RUN || s_q.phase == SER_RUN))
    else $error("start outside a run");
  divide_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == DIVIDE) |-> !discharge_start)
    else $error("start while dividing");
  wr_pulse_a: assert property (@(posedge clk) disable iff (reset)
    result.wr |=> !result.wr)
    else $error("post not a pulse");
  quo_width_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.phase == POST) |-> (s_q.quo[CNT_W-1:FRAC_W] == '0))
    else $error("ratio wider than fraction");
endmodule

// [temp_ratio_pkg.sv]
/*
  Shared constants and carrier types for the internal temperature ratio sequencer.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package temp_ratio_pkg;
  // ==========================================================
  // Configuration bit positions and result location
  localparam int unsigned CFG1_TEMP_EN_BIT = 8;
  localparam int unsigned CFG14_TEMP_SEL_BIT = 0;
  localparam logic [7:0] RESULT_ADDR = 8'hF5;
  // ==========================================================
  // Widths
  localparam int unsigned CNT_W = 24;
  localparam int unsigned FRAC_W = 20;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;

  // Path selection for the port analog switches
  typedef struct packed {
    logic gauge_port_c_second;
    logic gauge_port_d_first;
    logic temp_series_in;
    logic temp_resistor_value_select;
  } switch_ctrl_t;

  // Result posting to the result area
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [CNT_W-1:0] data;
  } result_wr_t;
endpackage

// [test_internal_temp_ratio_measure.sv]
/*
  Self-checking bench for the temperature ratio sequencer.
  Assumes the core model file and the package are compiled first.
*/
`timescale 1ns/1ps
module test_internal_temp_ratio_measure;
  import temp_ratio_pkg::*;
  logic clk = 0, reset = 1, cycle_end = 0;
  logic [15:0] cfg1 = 16'h0100;
  logic [23:0] cfg14 = 24'h000000, t_ref = 24'h001000, t_ser = 24'h001000;
  logic [7:0] delay = 8'h01;
  logic discharge_done, discharge_start;
  logic [CNT_W-1:0] discharge_time, ratio_out;
  switch_ctrl_t sw;
  result_wr_t result;
  int error_cnt = 0, n_tests = 0, n_wr = 0, n_start = 0, seed = 32'h5bdc45fe, gauge_ohm;
  longint exp_q;
  real r0 = 1.0, combined_tempco = 3500.0, temp_diff;
  always #2 clk = ~clk;
  always @(posedge clk)
    if (!reset)
    begin
      n_wr += result.wr;
      n_start += discharge_start;
    end
  internal_temp_ratio_measure internal_temp_ratio_measure_inst (.clk(clk), .reset(reset),
    .cfg1(cfg1), .cfg14(cfg14), .cycle_end(cycle_end), .discharge_done(discharge_done),
    .discharge_time(discharge_time), .sw(sw), .discharge_start(discharge_start),
    .result(result), .ratio_out(ratio_out));
  discharge_core_model discharge_core_model_inst (.clk(clk), .discharge_start(discharge_start),
    .sw(sw), .t_ref(t_ref), .t_ser(t_ser), .delay(delay), .discharge_done(discharge_done),
    .discharge_time(discharge_time));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host temperature from a posted value
  function automatic real host_temp(input logic [23:0] v);
    real cr;
    cr = 1.0 + real'(v[19:0]) / 1048576.0;
    host_temp = (cr - r0) / (combined_tempco / 1.0e6 * r0);
  endfunction
  // calibration at a known nominal temperature
  task automatic calibrate(input real tn);
    real cr, k;
    cr = 1.0 + real'(ratio_out[19:0]) / 1048576.0;
    k = 3500.0 * tn / 1.0e6;
    r0 = (k + cr) / (k + 1.0);
    combined_tempco = (cr - r0) / (r0 * tn) * 1.0e6;
  endtask
  task automatic wait_hi(input int which);
    int k;
    k = 0;
    while ((which ? result.wr : discharge_start) !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k[23:0] == 400, 24'h0);
  endtask
  task automatic pulse_end;
    cycle_end = 1;
    @(posedge clk);
    #1;
    cycle_end = 0;
  endtask
  task automatic run_cycle(input bit stray);
    exp_q = longint'(t_ser - t_ref) * 64'd1048576 / t_ref;
    @(posedge clk);
    #1;
    pulse_end();
    wait_hi(0);
    check({20'h0, sw}, {20'h0, 3'b110, cfg14[0]});
    @(posedge clk);
    #1;
    wait_hi(0);
    check({20'h0, sw}, {20'h0, 3'b111, cfg14[0]});
    if (stray)
      pulse_end();
    wait_hi(1);
    check({16'h0, result.addr}, 24'h0000F5);
    check({4'h0, result.data[19:0]}, {4'h0, exp_q[19:0]});
    check({4'h0, ratio_out[19:0]}, {4'h0, exp_q[19:0]});
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    reset = 0;
    for (int i = 0; i < 12; i++)
    begin
      t_ref = 24'h000800 + 24'($unsigned($random(seed)) & 32'h000FFFFF);
      t_ser = t_ref + 24'($unsigned($random(seed)) % t_ref);
      if (i == 0)
        t_ser = t_ref;
      gauge_ohm = ($random(seed) & 1) ? 350 : 1000;
      cfg14 = {23'($random(seed)), gauge_ohm == 350};
      delay = 8'h01 + 8'($unsigned($random(seed)) & 32'h0000000F);
      run_cycle(i[0]);
      if (i == 1 || i == 2)
        calibrate(i == 1 ? 20.0 : 50.0);
      else if (i > 2)
      begin
        temp_diff = host_temp(ratio_out) - host_temp(24'(exp_q));
        check({23'h0, temp_diff != 0.0}, 24'h0);
      end
    end
    // Disabled: no start, old ratio kept
    cfg1 = 16'hFEFF;
    pulse_end();
    repeat (60) @(posedge clk);
    #1;
    check({4'h0, ratio_out[19:0]}, {4'h0, exp_q[19:0]});
    check(n_start[23:0], 24'd24);
    check(n_wr[23:0], 24'd12);
    // Reset in mid-run drops the started measurement
    cfg1 = 16'h0100;
    pulse_end();
    wait_hi(0);
    reset = 1;
    repeat (3) @(posedge clk);
    #1;
    reset = 0;
    check({20'h0, sw}, 24'h0);
    check(ratio_out, 24'h0);
    repeat (30) @(posedge clk);
    #1;
    run_cycle(0);
    print_verdict();
  end
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule
